//--- dpc_ctrl_status.v
// Purpose: Control and status registers of a single-wire debug port.
// Assumes: Link layer supplies decoded register accesses and event pulses.
// Notes:   Port clock divider is reported as a select plus 16 MHz divide ratio.
`include "dpc_defs.vh"
module dpc_ctrl_status #(
   parameter TIMEOUT_CYCLES = `DPC_TIMEOUT_CYC
) (
   input  wire       core_clk,
   input  wire       sys_rst,
   // Link instruction register access (only path to registers)
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   // Link layer events, one-cycle pulses, plus the xfer_active level
   input  wire       ev_parity_err,
   input  wire       ev_frame_err,
   input  wire       ev_start_err,
   input  wire       ev_bus_err,
   input  wire       ev_contention,
   input  wire       acc_req,
   input  wire       acc_done,
   input  wire       key_urow_ok,
   input  wire       key_prog_ok,
   input  wire       key_erase_ok,
   input  wire       xfer_active,
   // System inputs from other domains
   input  wire       sys_in_reset,
   input  wire       sys_sleeping,
   input  wire       prog_enabled,
   input  wire       urow_enabled,
   input  wire       lock_bits_set,
   input  wire [2:0] crc_state,
   // Controls to link layer and system
   output reg        inter_byte_delay_en,
   output wire [1:0] idle_gap_bits,
   output reg        parity_check_en,
   output reg        response_allowed,
   output reg        neg_ack_allowed,
   output reg        contention_detect_en,
   output reg  [7:0] guard_cycles,
   output reg        phy_enable,
   output reg        system_reset_hold,
   output reg  [1:0] port_clock_divider,
   output reg  [2:0] port_clock_ratio,
   output reg        system_clock_request,
   output reg        user_row_commit,
   output reg        timeout_flag
);
   // Sign-off: no CPU path exists to these registers
   reg [7:0] ctrl_a;
   reg [2:0] ctrl_b;
   reg [2:0] error_signature;
   reg       user_row_key_flag;
   reg       mem_program_flag;
   reg       erase_key_flag;
   reg [7:0] system_reset_code;
   reg       system_reset_active;
   reg [16:0] to_count;
   reg       to_run;
   // Two-stage synchronisers for system inputs
   reg [7:0] sync1;
   reg [7:0] sync2;
   reg [2:0] crc1;
   reg [2:0] crc2;
   reg       prog_q;
   wire      in_reset_s  = sync2[0];
   wire      in_sleep_s  = sync2[1];
   wire      prog_en_s   = sync2[2];
   wire      urow_en_s   = sync2[3];
   wire      locked_s    = sync2[4];
   // Integer views of the timing counts, cut to width on purpose below
   localparam integer GUARD_MAX_I = `DPC_GUARD_MAX;
   localparam integer GAP_BITS_I  = `DPC_INTER_BYTE_DELAY_EN_BITS;
   wire      rd_err      = reg_rd && (reg_addr == `DPC_OFS_ERR);
   wire      rd_stat     = reg_rd && (reg_addr == `DPC_OFS_SYSSTAT);
   wire      port_off    = reg_wr && (reg_addr == `DPC_OFS_LINK_CONTROL_B) && reg_wdata[`DPC_B_PORTDIS];
   wire      rst_issue   = reg_wr && (reg_addr == `DPC_OFS_SYSTEM_RESET_CODE) && (reg_wdata == `DPC_RST_ASSERT);
   wire      port_rst    = sys_rst | port_off;

   assign idle_gap_bits = GAP_BITS_I[1:0];

   // Guard time decode: 128 >> code, reserved code keeps the longest wait
   function [7:0] dpc_guard;
      input [2:0] code;
      begin
         if (code == `DPC_GT_RSVD) begin
            dpc_guard = GUARD_MAX_I[7:0];
         end else begin
            dpc_guard = 8'h80 >> code;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers; first stage feeds only the second
   always @(posedge core_clk) begin
      if (sys_rst) begin
         sync1 <= 8'h00;
         sync2 <= 8'h10;
         crc1  <= 3'h0;
         crc2  <= 3'h0;
      end else begin
         sync1 <= {3'h0, lock_bits_set, urow_enabled, prog_enabled, sys_sleeping, sys_in_reset};
         sync2 <= sync1;
         crc1  <= crc_state;
         crc2  <= crc1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link configuration; a system reset returns it all to reset values, port disable likewise except that phy_enable and system_clock_request go low
   always @(posedge core_clk) begin
      if (port_rst) begin
         ctrl_a               <= 8'h00;
         ctrl_b               <= 3'h0;
         port_clock_divider   <= `DPC_CLKSEL_RST;
         // Port disable drops the request; a plain reset enables it
         system_clock_request <= ~port_off;
         system_reset_code    <= `DPC_RST_RELEASE;
         phy_enable           <= ~port_off;
      end else if (reg_wr) begin
         phy_enable <= 1'b1;
         case (reg_addr)
            `DPC_OFS_LINK_CONTROL_A: begin
               ctrl_a <= reg_wdata & 8'hbf;
            end
            `DPC_OFS_LINK_CONTROL_B: begin
               ctrl_b <= reg_wdata[4:2];
            end
            `DPC_OFS_SYSTEM_RESET_CODE: begin
               system_reset_code <= reg_wdata;
            end
            `DPC_OFS_CLKSEL: begin
               port_clock_divider <= reg_wdata[1:0];
            end
            `DPC_OFS_SYSCTL: begin
               system_clock_request <= reg_wdata[`DPC_C_SYSTEM_CLOCK_REQUEST];
            end
            default: begin
               ctrl_b <= ctrl_b;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded control outputs
   always @(posedge core_clk) begin
      if (port_rst) begin
         inter_byte_delay_en  <= 1'b0;
         parity_check_en      <= 1'b1;
         response_allowed     <= 1'b1;
         neg_ack_allowed      <= 1'b1;
         contention_detect_en <= 1'b1;
         guard_cycles         <= GUARD_MAX_I[7:0];
         system_reset_hold    <= 1'b0;
         port_clock_ratio     <= 3'h4;
      end else begin
         inter_byte_delay_en  <= ctrl_a[`DPC_A_INTER_BYTE_DELAY_EN];
         parity_check_en      <= ~ctrl_a[`DPC_A_PARIGN];
         response_allowed     <= ~ctrl_a[`DPC_A_RSPSUP];
         // Neg-ack only dropped for reset during a transfer
         neg_ack_allowed      <= ~(ctrl_b[2] && xfer_active && in_reset_s);
         contention_detect_en <= ~ctrl_b[1];
         guard_cycles         <= dpc_guard(ctrl_a[2:0]);
         // Hold only on 0x59; 0x00 or reserved values release
         system_reset_hold    <= (system_reset_code == `DPC_RST_ASSERT);
         // Divide ratio from a 16 MHz source; reserved 0 keeps 4 MHz
         case (port_clock_divider)
            `DPC_CLKSEL_16M: port_clock_ratio <= 3'h1;
            `DPC_CLKSEL_8M:  port_clock_ratio <= 3'h2;
            default:         port_clock_ratio <= 3'h4;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access layer time-out counter
   always @(posedge core_clk) begin
      if (port_rst) begin
         to_run       <= 1'b0;
         to_count     <= 17'h00000;
         timeout_flag <= 1'b0;
      end else begin
         timeout_flag <= 1'b0;
         if (acc_done || ctrl_a[`DPC_A_TODIS]) begin
            to_run   <= 1'b0;
            to_count <= 17'h00000;
         end else if (acc_req) begin
            to_run   <= 1'b1;
            to_count <= 17'h00000;
         end else if (to_run) begin
            if (to_count == TIMEOUT_CYCLES[16:0] - 17'h00001) begin
               timeout_flag <= 1'b1;
               to_run       <= 1'b0;
            end
            to_count <= to_count + 17'h00001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error signature: new fault wins over the clearing read
   always @(posedge core_clk) begin
      if (port_rst) begin
         error_signature <= `DPC_SIG_NONE;
      end else if (ev_contention && ~ctrl_b[1]) begin
         error_signature <= `DPC_SIG_CONTEND;
      end else if (ev_bus_err) begin
         error_signature <= `DPC_SIG_BUS;
      end else if (timeout_flag) begin
         error_signature <= `DPC_SIG_TIMEOUT;
      end else if (ev_start_err) begin
         error_signature <= `DPC_SIG_START;
      end else if (ev_frame_err) begin
         error_signature <= `DPC_SIG_FRAME;
      end else if (ev_parity_err && ~ctrl_a[`DPC_A_PARIGN]) begin
         error_signature <= `DPC_SIG_PARITY;
      end else if (rd_err) begin
         error_signature <= `DPC_SIG_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Key flags and user row commit
   always @(posedge core_clk) begin
      if (port_rst) begin
         user_row_key_flag <= 1'b0;
         mem_program_flag  <= 1'b0;
         erase_key_flag    <= 1'b0;
         user_row_commit   <= 1'b0;
         prog_q            <= 1'b0;
      end else begin
         prog_q          <= prog_en_s;
         user_row_commit <= reg_wr && (reg_addr == `DPC_OFS_SYSCTL) && reg_wdata[`DPC_C_USER_ROW_FINISHED]
                            && user_row_key_flag;
         if (key_urow_ok) begin
            user_row_key_flag <= 1'b1;
         end else if (reg_wr && (reg_addr == `DPC_OFS_KEY) && reg_wdata[`DPC_K_UROW]) begin
            user_row_key_flag <= 1'b0;
         end
         if (key_prog_ok) begin
            mem_program_flag <= 1'b1;
         end else if (prog_en_s && ~prog_q) begin
            mem_program_flag <= 1'b0;
         end
         if (key_erase_ok) begin
            erase_key_flag <= 1'b1;
         end else if (rst_issue) begin
            erase_key_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset active: sticky while in reset, clear on read unless still in reset
   always @(posedge core_clk) begin
      if (port_rst) begin
         system_reset_active <= 1'b0;
      end else if (in_reset_s || system_reset_hold) begin
         system_reset_active <= 1'b1;
      end else if (rd_stat) begin
         system_reset_active <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data register
   always @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `DPC_OFS_ERR:    reg_rdata <= {5'h00, error_signature};
            `DPC_OFS_LINK_CONTROL_A:  reg_rdata <= ctrl_a;
            `DPC_OFS_LINK_CONTROL_B:  reg_rdata <= {3'h0, ctrl_b, 2'h0};
            `DPC_OFS_KEY:    reg_rdata <= {2'h0, user_row_key_flag, mem_program_flag, erase_key_flag, 3'h0};
            `DPC_OFS_SYSTEM_RESET_CODE: reg_rdata <= system_reset_code;
            `DPC_OFS_CLKSEL: reg_rdata <= {6'h00, port_clock_divider};
            `DPC_OFS_SYSCTL: reg_rdata <= {7'h00, system_clock_request};
            `DPC_OFS_SYSSTAT: begin
               reg_rdata <= {2'h0, system_reset_active, in_sleep_s, prog_en_s, urow_en_s,
                             1'b0, locked_s};
            end
            `DPC_OFS_CRC:    reg_rdata <= {5'h00, crc2};
            default:         reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule

//--- dpc_defs.vh
// Purpose: Constants for the debug port control and status register set.
// Assumes: Registers are reached only through the link instruction port.
// Notes:   All offsets, fields, reset values and counts live here.
// Behaviour
// - Link faults load signature 1, 2 or 4
// - Time-out 3, bus error 6, contention 7
// - Inter-byte delay adds two idle bits
// - Parity ignore skips received parity checks
// - Time-out after 65536 port cycles unless disabled
// - Response suppress blocks all response signatures
// - Guard time 128 halving to 2 cycles
// - Neg-ack suppress on reset during transfers
// - Contention detection off while bit set
// - Port disable resets configuration and keys
// - User row key flag set; write resets session
// - Programming key cleared when programming enabled
// - Erase key cleared by erase reset request
// - Code 0x59 holds reset, 0x00 releases
// - Clock select 1/2/3 gives 16/8/4 MHz
// - User row done writable only with key
// - Clock request held while bit set
// - Reset active status clears on read
// - In-sleep status follows system sleep
// - Programming and user row enable status bits
// - Lock status reads one while locked
// - CRC status one-hot busy/ok/fail
// - Registers reachable only through link instructions
`ifndef DPC_DEFS_VH
`define DPC_DEFS_VH
////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define DPC_OFS_ERR      4'h1
`define DPC_OFS_LINK_CONTROL_A    4'h2
`define DPC_OFS_LINK_CONTROL_B    4'h3
`define DPC_OFS_KEY      4'h7
`define DPC_OFS_SYSTEM_RESET_CODE   4'h8
`define DPC_OFS_CLKSEL   4'h9
`define DPC_OFS_SYSCTL   4'ha
`define DPC_OFS_SYSSTAT  4'hb
`define DPC_OFS_CRC      4'hc
////////////////////////////////////////////////////////////////////////////////
// Field positions
`define DPC_A_INTER_BYTE_DELAY_EN      7
`define DPC_A_PARIGN     5
`define DPC_A_TODIS      4
`define DPC_A_RSPSUP     3
`define DPC_B_NACKSUP    4
`define DPC_B_CCOFF      3
`define DPC_B_PORTDIS    2
`define DPC_K_UROW       5
`define DPC_K_PROG       4
`define DPC_K_ERASE      3
`define DPC_S_RSTACT     5
`define DPC_S_SLEEP      4
`define DPC_S_PROG       3
`define DPC_S_UROW       2
`define DPC_S_LOCK       0
`define DPC_C_USER_ROW_FINISHED   1
`define DPC_C_SYSTEM_CLOCK_REQUEST     0
////////////////////////////////////////////////////////////////////////////////
// Values
`define DPC_SIG_NONE     3'h0
`define DPC_SIG_PARITY   3'h1
`define DPC_SIG_FRAME    3'h2
`define DPC_SIG_TIMEOUT  3'h3
`define DPC_SIG_START    3'h4
`define DPC_SIG_BUS      3'h6
`define DPC_SIG_CONTEND  3'h7
`define DPC_RST_ASSERT   8'h59
`define DPC_RST_RELEASE  8'h00
`define DPC_CLKSEL_RST   2'h3
`define DPC_CLKSEL_16M   2'h1
`define DPC_CLKSEL_8M    2'h2
`define DPC_GT_RSVD      3'h7
`define DPC_CRC_OFF      3'h0
`define DPC_CRC_BUSY     3'h1
`define DPC_CRC_OK       3'h2
`define DPC_CRC_FAIL     3'h4
`define DPC_TIMEOUT_CYC  65536
`define DPC_GUARD_MAX    128
`define DPC_INTER_BYTE_DELAY_EN_BITS   2
`endif

//--- dpc_ctrl_status_monitor.sv
// Purpose: Concurrent checks on the ports of the register block.
// Assumes: Decoded outputs follow a register write two edges later.
// Notes:   Attached to the design by the bind at the foot of this file.
module dpc_ctrl_status_monitor (
   input wire       core_clk,
   input wire       sys_rst,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire       acc_req,
   input wire       timeout_flag,
   input wire       inter_byte_delay_en,
   input wire       parity_check_en,
   input wire       response_allowed,
   input wire       contention_detect_en,
   input wire [7:0] guard_cycles,
   input wire       phy_enable,
   input wire       system_reset_hold,
   input wire       user_row_commit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] exp_guard;
   wire        wr_a = reg_wr && reg_addr == 4'h2;
   wire        wr_b = reg_wr && reg_addr == 4'h3;
   wire        wr_r = reg_wr && reg_addr == 4'h8;
   wire        wr_u = reg_wr && reg_addr == 4'ha && reg_wdata[1];
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Guard length of the last code written; the reserved code falls back to the longest wait
   always @(posedge core_clk)
      if (wr_a) exp_guard <= (reg_wdata[2:0] == 3'h7) ? 8'h80 : 8'h80 >> reg_wdata[2:0];
   a_guard_time_code: assert property (wr_a |-> ##2 guard_cycles == exp_guard)
      else $error("guard time wrong");
   a_inter_byte_delay_en_follows: assert property (wr_a |-> ##2 inter_byte_delay_en == $past(reg_wdata[7], 2))
      else $error("inter-byte delay wrong");
   a_parity_follows: assert property (wr_a |-> ##2 parity_check_en != $past(reg_wdata[5], 2))
      else $error("parity check enable wrong");
   a_response_follows: assert property (wr_a |-> ##2 response_allowed != $past(reg_wdata[3], 2))
      else $error("response enable wrong");
   a_contention_follows: assert property (wr_b && !reg_wdata[2] |-> ##2 contention_detect_en != $past(reg_wdata[3], 2))
      else $error("contention enable wrong");
   a_port_disable: assert property (wr_b && reg_wdata[2] |-> ##2 !phy_enable && guard_cycles == 8'h80)
      else $error("port disable incomplete");
   a_reset_hold: assert property (wr_r && (reg_wdata == 8'h59 || reg_wdata == 8'h00) |-> ##2 system_reset_hold == $past(reg_wdata[0], 2))
      else $error("reset hold wrong");
   // Time-out must not come early; the signature read in the bench only shows that it has come by then
   a_timeout_early: assert property (acc_req |=> !timeout_flag [*8])
      else $error("time-out too early");
   a_commit_source: assert property (user_row_commit |-> $past(wr_u) || $past(wr_u, 2))
      else $error("commit without write");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind dpc_ctrl_status dpc_ctrl_status_monitor mon (
   .core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .acc_req, .timeout_flag,
   .inter_byte_delay_en, .parity_check_en, .response_allowed, .contention_detect_en, .guard_cycles,
   .phy_enable, .system_reset_hold, .user_row_commit);

//--- dpc_dbg_model.sv
// Purpose: Debugger side of the link, issuing single register accesses.
// Assumes: One strobe cycle per access; read data valid the cycle after.
// Notes:   Idle address and data lines show the inverse of the last value.
module dpc_dbg_model (
   input  wire        core_clk,
   output logic       reg_wr,
   output logic       reg_rd,
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   input  wire  [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   // Store through a link instruction, the only way into the registers
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // Load; data taken once the registered answer has landed
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

//--- test_dpc_ctrl_status.sv
// Purpose: Self-checking bench for the debug port register block.
// Assumes: Inputs change on the falling edge; time-out count shortened to 16.
// Notes:   Register accesses go through the debugger model only.
module test_dpc_ctrl_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TOUT = 16;
   logic       core_clk, sys_rst, xfer_active, sys_in_reset, sys_sleeping;
   logic       prog_enabled, urow_enabled, lock_bits_set;
   logic [2:0] crc_state;
   logic [9:0] pv;
   logic [7:0] rv;
   int         n_errors, n_tests, n_commit;
   logic [3:0] ra [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc};
   logic [7:0] rr [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00};
   logic [2:0] sg [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
   logic [2:0] cr [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   logic [7:0] ck [4] = '{8'h00, 8'h05, 8'h0a, 8'h13};
   wire        reg_wr, reg_rd, ev_parity_err, ev_frame_err, ev_start_err, ev_bus_err, ev_contention;
   wire        acc_req, acc_done, key_urow_ok, key_prog_ok, key_erase_ok, inter_byte_delay_en;
   wire        parity_check_en, response_allowed, neg_ack_allowed, contention_detect_en, phy_enable;
   wire        system_reset_hold, system_clock_request, user_row_commit, timeout_flag;
   wire [3:0]  reg_addr;
   wire [7:0]  reg_wdata, reg_rdata, guard_cycles;
   wire [1:0]  idle_gap_bits, port_clock_divider;
   wire [2:0]  port_clock_ratio;
   // Event and key pulses share one vector so one task drives them all
   assign {key_erase_ok, key_prog_ok, key_urow_ok, acc_done, acc_req, ev_contention,
           ev_bus_err, ev_start_err, ev_frame_err, ev_parity_err} = pv;
   dpc_ctrl_status #(.TIMEOUT_CYCLES(TOUT)) dut (
      .core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .ev_parity_err,
      .ev_frame_err, .ev_start_err, .ev_bus_err, .ev_contention, .acc_req, .acc_done, .key_urow_ok,
      .key_prog_ok, .key_erase_ok, .xfer_active, .sys_in_reset, .sys_sleeping, .prog_enabled,
      .urow_enabled, .lock_bits_set, .crc_state, .inter_byte_delay_en, .idle_gap_bits,
      .parity_check_en, .response_allowed, .neg_ack_allowed, .contention_detect_en, .guard_cycles,
      .phy_enable, .system_reset_hold, .port_clock_divider, .port_clock_ratio,
      .system_clock_request, .user_row_commit, .timeout_flag);
   dpc_dbg_model m (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Commit pulses are counted, so a refused write shows as a missing count
   always @(posedge core_clk) if (user_row_commit === 1'b1) n_commit++;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      m.rd(a, rv);
      chk($sformatf("reg %h", a), e, rv);
   endtask
   task automatic pl(input logic [9:0] v);
      @(negedge core_clk);
      pv = v;
      @(negedge core_clk);
      pv = '0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Watchdog: the sequence needs well under 2000 cycles
   initial begin
      #(20 * 6000);
      n_errors++;
      print_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      lock_bits_set = 1'b1;
      {xfer_active, sys_in_reset, sys_sleeping, prog_enabled, urow_enabled, crc_state, pv} = '0;
      wt(16);
      sys_rst = 1'b0;
      foreach (ra[i]) rdc(ra[i], rr[i]);
      chk("guard", 8'h80, guard_cycles);
      chk("system_clock_request", 8'h01, {7'h0, system_clock_request});
      $display("test reset finished");
      // Each event fault code (all but time-out), cleared by the read that reports it
      for (int i = 0; i < 5; i++) begin
         pl(10'h1 << i);
         rdc(4'h1, {5'h0, sg[i]});
         rdc(4'h1, 8'h00);
      end
      pl(10'h020);
      wt(TOUT + 4);
      rdc(4'h1, 8'h03);
      pl(10'h020);
      pl(10'h040);
      wt(TOUT + 4);
      rdc(4'h1, 8'h00);
      m.wr(4'h2, 8'h10);
      pl(10'h020);
      wt(TOUT + 4);
      rdc(4'h1, 8'h00);
      $display("test signature finished");
      for (int c = 0; c < 8; c++) begin
         m.wr(4'h2, 8'ha8 | c[7:0]);
         wt(2);
         chk("guard", (c == 7) ? 8'h80 : 8'h80 >> c, guard_cycles);
      end
      chk("ctrl", 8'h82, {inter_byte_delay_en, parity_check_en, response_allowed, 3'h0, idle_gap_bits});
      m.wr(4'h2, 8'hff);
      rdc(4'h2, 8'hbf);
      m.wr(4'h3, 8'h08);
      pl(10'h010);
      rdc(4'h1, 8'h00);
      m.wr(4'h3, 8'h10);
      pl(10'h010);
      rdc(4'h1, 8'h07);
      xfer_active = 1'b1;
      sys_in_reset = 1'b1;
      wt(4);
      chk("nack", 8'h00, {7'h0, neg_ack_allowed});
      xfer_active = 1'b0;
      sys_in_reset = 1'b0;
      wt(4);
      rdc(4'hb, 8'h21);
      rdc(4'hb, 8'h01);
      $display("test control finished");
      pl(10'h380);
      rdc(4'h7, 8'h38);
      prog_enabled = 1'b1;
      wt(4);
      rdc(4'h7, 8'h28);
      rdc(4'hb, 8'h09);
      prog_enabled = 1'b0;
      m.wr(4'h8, 8'h59);
      wt(2);
      sys_in_reset = system_reset_hold;
      chk("hold", 8'h01, {7'h0, system_reset_hold});
      rdc(4'h7, 8'h20);
      m.wr(4'h8, 8'h00);
      wt(2);
      sys_in_reset = system_reset_hold;
      wt(4);
      rdc(4'hb, 8'h21);
      m.wr(4'ha, 8'h03);
      wt(3);
      chk("commit", 8'h01, n_commit[7:0]);
      m.wr(4'h7, 8'h20);
      rdc(4'h7, 8'h00);
      m.wr(4'ha, 8'h02);
      wt(3);
      chk("commit", 8'h01, n_commit[7:0]);
      chk("system_clock_request", 8'h00, {7'h0, system_clock_request});
      $display("test keys finished");
      for (int d = 1; d < 4; d++) begin
         m.wr(4'h9, d[7:0]);
         wt(2);
         chk("clksel", ck[d], {3'h0, port_clock_ratio, port_clock_divider});
      end
      {sys_sleeping, urow_enabled, lock_bits_set} = 3'b110;
      wt(4);
      rdc(4'hb, 8'h14);
      for (int i = 0; i < 4; i++) begin
         crc_state = cr[i];
         wt(4);
         rdc(4'hc, {5'h0, cr[i]});
      end
      m.wr(4'h2, 8'h81);
      pl(10'h380);
      m.wr(4'h3, 8'h04);
      wt(2);
      chk("phy", 8'h00, {7'h0, phy_enable});
      chk("system_clock_request", 8'h00, {7'h0, system_clock_request});
      rdc(4'h2, 8'h00);
      rdc(4'h7, 8'h00);
      rdc(4'h9, 8'h03);
      $display("test status finished");
      print_verdict;
   end
endmodule
